/* File: core/mrd_pkg.sv */
// Package for the memory region decoder: region bases, target codes
// and the access-size encoding shared by the decoder and its bench.
// Assumes a 32-bit byte address space and one core clock.
package mrd_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [31:0] MRD_CODE_BASE     = 32'h0000_0000;
    localparam logic [31:0] MRD_SRAM_BASE     = 32'h2000_0000;
    localparam logic [31:0] MRD_PERIPH_BASE   = 32'h4000_0000;
    localparam logic [31:0] MRD_PERIPH_LAST   = 32'h5FFF_FFFF;
    localparam logic [31:0] MRD_EXTRAM_BASE   = 32'h6000_0000;
    localparam logic [31:0] MRD_EXTRAM_LAST   = 32'h9FFF_FFFF;
    localparam logic [31:0] MRD_EXTDEV_BASE   = 32'hA000_0000;
    localparam logic [31:0] MRD_PRIVSYS_BASE  = 32'hE000_0000;
    localparam logic [31:0] MRD_VENDOR_BASE   = 32'hE010_0000;
    localparam logic [31:0] MRD_VENDOR_RES_LAST = 32'hEFFF_FFFF;
    localparam logic [31:0] MRD_VENDOR_RSRC   = 32'hF000_0000;

    // ------------------------------------------------------------------
    // Build option and field positions
    // ------------------------------------------------------------------
    localparam bit          MRD_SEC_EXT_PRESENT = 1'b1;
    localparam int          MRD_PROT_NS_BIT     = 1;
    localparam logic [2:0]  MRD_PROT_RESET      = 3'h0;

    // ------------------------------------------------------------------
    // Access size of one element
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MRD_SIZE_BYTE = 2'h0,
        MRD_SIZE_HALF = 2'h1,
        MRD_SIZE_WORD = 2'h2,
        MRD_SIZE_DWORD = 2'h3
    } mrd_size_t;

    // ------------------------------------------------------------------
    // Target interface of a decoded access
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MRD_TGT_NONE     = 3'h0,
        MRD_TGT_IMEM     = 3'h1,
        MRD_TGT_DMEM     = 3'h2,
        MRD_TGT_AXI      = 3'h3,
        MRD_TGT_AHB      = 3'h4,
        MRD_TGT_APB      = 3'h5,
        MRD_TGT_INTERNAL = 3'h6
    } mrd_tgt_t;

    // ------------------------------------------------------------------
    // Coarse region classes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MRD_REG_CODE    = 3'h0,
        MRD_REG_SRAM    = 3'h1,
        MRD_REG_PERIPH  = 3'h2,
        MRD_REG_EXTRAM  = 3'h3,
        MRD_REG_EXTDEV  = 3'h4,
        MRD_REG_PRIVSYS = 3'h5,
        MRD_REG_VENDOR  = 3'h6
    } mrd_region_t;

endpackage : mrd_pkg

/* File: core/mrd_decoder.sv */
// Memory region decoder: one request per cycle in, one registered
// decision per cycle out (target, type, security, faults).
// Assumes memory hit, attribution and remap inputs are valid with the
// request and that all inputs are synchronous to i_ref_clk.
//
// Behaviour
// - Code region goes to instruction memory or AXI
// - SRAM region goes to data memory or AXI
// - Peripheral data AHB or AXI, fetch AXI
// - External RAM and device only on AXI
// - Private system: no fetch, internal or APB
// - Vendor region: no fetch, reserved part faults, other data to AHB
// - Security shown on AXI, AHB, APB flags
// - Security from state plus attribution units; system-region data from state alone
// - No security extension means all Non-secure
// - Tight memory has no flag, gate instead
// - Normal unaligned allowed unless trap enabled or vector access
// - nE Device held internally, attribute passed out
// - Device subtypes alike, vector may merge
// - Unaligned Device data access raises alignment fault
// - Device data accesses coherent to all observers
// - Default Device regions, others Normal
// - Remap both ways except system regions and tight memory
// - Private system always Device nGnRnE
// - Vendor nGnRE, may be nE, Normal unpredictable
// - No bit-band aliasing, address passed unchanged
module mrd_decoder
    import mrd_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_req_valid,
    input  wire logic [31:0] i_req_addr,
    input  wire logic        i_req_fetch,
    input  wire logic        i_req_write,
    input  wire logic [1:0]  i_req_size,
    input  wire logic        i_req_vector,
    input  wire logic        i_cpu_secure,
    input  wire logic        i_internal_attr_ns,
    input  wire logic        i_external_attr_ns,
    input  wire logic        i_imem_hit,
    input  wire logic        i_dmem_hit,
    input  wire logic        i_periph_ahb_sel,
    input  wire logic        i_privsys_internal,
    input  wire logic        i_mem_gate_allow,
    input  wire logic        i_unalign_trap,
    input  wire logic        i_remap_valid,
    input  wire logic        i_remap_device,
    input  wire logic        i_remap_no_early_ack,
    output logic             o_rsp_valid,
    output logic [31:0]      o_rsp_addr,
    output logic [2:0]       o_rsp_target,
    output logic             o_rsp_write,
    output logic             o_bus_fault,
    output logic             o_align_fault,
    output logic             o_is_device,
    output logic             o_early_ack,
    output logic             o_wait_final_resp,
    output logic             o_merge_ok,
    output logic             o_coherent,
    output logic             o_unpredictable,
    output logic [2:0]       o_axi_arprot,
    output logic [2:0]       o_axi_awprot,
    output logic             o_ahb_nonsecure_flag,
    output logic [2:0]       o_apb_pprot
);

    // ------------------------------------------------------------------
    // Region classification
    // ------------------------------------------------------------------
    mrd_region_t region;
    logic        vendor_reserved;

    // Top three address bits give the coarse region; the top one splits
    // further because the top eighth holds two regions of unequal size.
    always_comb begin
        region = MRD_REG_CODE;
        if (i_req_addr >= MRD_VENDOR_BASE) begin
            region = MRD_REG_VENDOR;
        end else if (i_req_addr >= MRD_PRIVSYS_BASE) begin
            region = MRD_REG_PRIVSYS;
        end else if (i_req_addr >= MRD_EXTDEV_BASE) begin
            region = MRD_REG_EXTDEV;
        end else if (i_req_addr >= MRD_EXTRAM_BASE) begin
            region = MRD_REG_EXTRAM;
        end else if (i_req_addr >= MRD_PERIPH_BASE) begin
            region = MRD_REG_PERIPH;
        end else if (i_req_addr >= MRD_SRAM_BASE) begin
            region = MRD_REG_SRAM;
        end
    end

    // Lower part of the vendor region holds no resources
    assign vendor_reserved = (region == MRD_REG_VENDOR) &&
                             (i_req_addr <= MRD_VENDOR_RES_LAST);

    // ------------------------------------------------------------------
    // Target selection and bus faults
    // ------------------------------------------------------------------
    mrd_tgt_t tgt_nxt;
    logic     bus_fault_nxt;

    // Faulting accesses select no target, so no transaction is issued
    always_comb begin
        tgt_nxt       = MRD_TGT_AXI;
        bus_fault_nxt = 1'b0;
        case (region)
            MRD_REG_CODE: begin
                tgt_nxt = i_imem_hit ? MRD_TGT_IMEM : MRD_TGT_AXI;
            end
            MRD_REG_SRAM: begin
                tgt_nxt = i_dmem_hit ? MRD_TGT_DMEM : MRD_TGT_AXI;
            end
            MRD_REG_PERIPH: begin
                if (!i_req_fetch && i_periph_ahb_sel) begin
                    tgt_nxt = MRD_TGT_AHB;
                end else begin
                    tgt_nxt = MRD_TGT_AXI;
                end
            end
            MRD_REG_EXTRAM, MRD_REG_EXTDEV: begin
                tgt_nxt = MRD_TGT_AXI;
            end
            MRD_REG_PRIVSYS: begin
                if (i_req_fetch) begin
                    bus_fault_nxt = 1'b1;
                end else if (i_privsys_internal) begin
                    tgt_nxt = MRD_TGT_INTERNAL;
                end else begin
                    tgt_nxt = MRD_TGT_APB;
                end
            end
            MRD_REG_VENDOR: begin
                if (i_req_fetch || vendor_reserved) begin
                    bus_fault_nxt = 1'b1;
                end else begin
                    tgt_nxt = MRD_TGT_AHB;
                end
            end
            default: begin
                bus_fault_nxt = 1'b1;
            end
        endcase
        // Tight memory ports carry no security flag: the gate decides
        if ((tgt_nxt == MRD_TGT_IMEM || tgt_nxt == MRD_TGT_DMEM) &&
            !i_mem_gate_allow) begin
            bus_fault_nxt = 1'b1;
        end
        if (bus_fault_nxt) begin
            tgt_nxt = MRD_TGT_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Memory type after default map and remap
    // ------------------------------------------------------------------
    logic dflt_device;
    logic device_nxt;
    logic early_nxt;
    logic unpred_nxt;

    assign dflt_device = (region == MRD_REG_PERIPH) ||
                         (region == MRD_REG_EXTDEV) ||
                         (region == MRD_REG_PRIVSYS) ||
                         (region == MRD_REG_VENDOR);

    // Private system is pinned to nGnRnE; vendor stays Device even when
    // software asks for Normal, and that request is flagged instead.
    always_comb begin
        device_nxt = dflt_device;
        early_nxt  = 1'b1;
        unpred_nxt = 1'b0;
        if (i_remap_valid) begin
            device_nxt = i_remap_device;
            early_nxt  = !i_remap_no_early_ack;
        end
        if (region == MRD_REG_PRIVSYS) begin
            device_nxt = 1'b1;
            early_nxt  = 1'b0;
        end else if (region == MRD_REG_VENDOR) begin
            device_nxt = 1'b1;
            unpred_nxt = i_remap_valid && !i_remap_device;
            early_nxt  = !(i_remap_valid && i_remap_device &&
                           i_remap_no_early_ack);
        end
        // Tight memories stay Normal whatever the remap says
        if (tgt_nxt == MRD_TGT_IMEM || tgt_nxt == MRD_TGT_DMEM) begin
            device_nxt = 1'b0;
        end
        if (!device_nxt) begin
            early_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Alignment
    // ------------------------------------------------------------------
    logic misaligned;
    logic align_fault_nxt;

    always_comb begin
        case (i_req_size)
            MRD_SIZE_HALF:  misaligned = i_req_addr[0];
            MRD_SIZE_WORD:  misaligned = |i_req_addr[1:0];
            MRD_SIZE_DWORD: misaligned = |i_req_addr[2:0];
            default:        misaligned = 1'b0;
        endcase
    end

    // Bus faults take priority: an access is reported with one cause
    assign align_fault_nxt = !bus_fault_nxt && !i_req_fetch && misaligned &&
                             (device_nxt ||
                              i_unalign_trap ||
                              i_req_vector ||
                              tgt_nxt == MRD_TGT_APB);

    // ------------------------------------------------------------------
    // Security attribute
    // ------------------------------------------------------------------
    logic state_only;
    logic nonsecure_nxt;

    // System regions judge data accesses by processor state alone
    assign state_only = !i_req_fetch && ((region == MRD_REG_PRIVSYS) ||
                                         (region == MRD_REG_VENDOR));

    always_comb begin
        if (!MRD_SEC_EXT_PRESENT) begin
            nonsecure_nxt = 1'b1;
        end else if (state_only) begin
            nonsecure_nxt = !i_cpu_secure;
        end else begin
            // Secure when the core is Secure and either unit says Secure
            nonsecure_nxt = !i_cpu_secure ||
                            (i_internal_attr_ns && i_external_attr_ns);
        end
    end

    // ------------------------------------------------------------------
    // Decision register
    // ------------------------------------------------------------------
    logic issue;

    assign issue = i_req_valid && !bus_fault_nxt && !align_fault_nxt;

    // Target, address and faults
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_rsp_valid   <= 1'b0;
            o_rsp_addr    <= 32'h0000_0000;
            o_rsp_target  <= MRD_TGT_NONE;
            o_rsp_write   <= 1'b0;
            o_bus_fault   <= 1'b0;
            o_align_fault <= 1'b0;
        end else begin
            o_rsp_valid   <= i_req_valid;
            o_rsp_addr    <= i_req_addr;
            o_rsp_target  <= issue ? tgt_nxt : MRD_TGT_NONE;
            o_rsp_write   <= i_req_write;
            o_bus_fault   <= i_req_valid && bus_fault_nxt;
            o_align_fault <= i_req_valid && align_fault_nxt;
        end
    end

    // Memory attributes; nE accesses must wait for the final response
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_is_device       <= 1'b0;
            o_early_ack       <= 1'b0;
            o_wait_final_resp <= 1'b0;
            o_merge_ok        <= 1'b0;
            o_coherent        <= 1'b0;
            o_unpredictable   <= 1'b0;
        end else begin
            o_is_device       <= i_req_valid && device_nxt;
            o_early_ack       <= i_req_valid && early_nxt;
            o_wait_final_resp <= i_req_valid && device_nxt &&
                                 !early_nxt;
            // Gathering bit is ignored: only vector ops merge on Device
            o_merge_ok        <= i_req_valid &&
                                 (!device_nxt || i_req_vector);
            o_coherent        <= i_req_valid && device_nxt;
            o_unpredictable   <= i_req_valid && unpred_nxt;
        end
    end

    // Security flags; privileged bit stays 0 since privilege is not
    // decoded here; the instruction bit follows fetch on AXI reads and stays 0 on AXI writes and APB.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_axi_arprot         <= MRD_PROT_RESET;
            o_axi_awprot         <= MRD_PROT_RESET;
            o_ahb_nonsecure_flag <= 1'b0;
            o_apb_pprot          <= MRD_PROT_RESET;
        end else begin
            o_axi_arprot         <= {i_req_fetch, nonsecure_nxt, 1'b0};
            o_axi_awprot         <= {1'b0, nonsecure_nxt, 1'b0};
            o_ahb_nonsecure_flag <= nonsecure_nxt;
            o_apb_pprot          <= {1'b0, nonsecure_nxt, 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking mrd_cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    AST_CODE_ROUTE: assert property (
        i_req_valid && i_req_addr < MRD_SRAM_BASE && i_mem_gate_allow
        |=> o_align_fault || o_rsp_target ==
            ($past(i_imem_hit) ? MRD_TGT_IMEM : MRD_TGT_AXI))
        else $error("code region routed wrongly");

    AST_SRAM_ROUTE: assert property (
        i_req_valid && region == MRD_REG_SRAM && i_dmem_hit &&
        i_mem_gate_allow && !misaligned
        |=> o_rsp_target == MRD_TGT_DMEM)
        else $error("SRAM hit not sent to data memory");

    AST_PERIPH_FETCH: assert property (
        i_req_valid && i_req_fetch && region == MRD_REG_PERIPH
        |=> o_rsp_target == MRD_TGT_AXI && !o_bus_fault)
        else $error("peripheral fetch not on AXI");

    AST_EXT_AXI: assert property (
        i_req_valid && i_req_addr >= MRD_EXTRAM_BASE &&
        i_req_addr < MRD_PRIVSYS_BASE
        |=> o_rsp_target inside {MRD_TGT_AXI, MRD_TGT_NONE})
        else $error("external region left AXI");

    AST_SYS_FETCH: assert property (
        i_req_valid && i_req_fetch && i_req_addr >= MRD_PRIVSYS_BASE
        |=> o_bus_fault && o_rsp_target == MRD_TGT_NONE)
        else $error("system fetch not faulted");

    AST_VENDOR_DATA: assert property (
        i_req_valid && !i_req_fetch && i_req_addr >= MRD_VENDOR_RSRC &&
        !misaligned
        |=> o_rsp_target == MRD_TGT_AHB && !o_bus_fault)
        else $error("vendor data not on AHB");

    AST_VENDOR_RES: assert property (
        i_req_valid && !i_req_fetch && vendor_reserved
        |=> o_bus_fault && !o_align_fault)
        else $error("reserved vendor access not faulted");

    AST_SEC_FLAGS: assert property (
        o_rsp_valid |-> o_ahb_nonsecure_flag ==
            o_axi_arprot[MRD_PROT_NS_BIT] &&
            o_apb_pprot[MRD_PROT_NS_BIT] == o_axi_awprot[MRD_PROT_NS_BIT])
        else $error("security flags disagree");

    AST_SEC_STATE_ONLY: assert property (
        i_req_valid && !i_req_fetch && region == MRD_REG_PRIVSYS
        |=> o_ahb_nonsecure_flag == !$past(i_cpu_secure))
        else $error("system data security not from state");

    AST_NS_CORE: assert property (
        i_req_valid && !i_cpu_secure |=> o_ahb_nonsecure_flag)
        else $error("Non-secure core issued Secure request");

    AST_MEM_GATE: assert property (
        i_req_valid && region == MRD_REG_CODE && i_imem_hit &&
        !i_mem_gate_allow |=> o_bus_fault)
        else $error("TIGHT_COUPLED_MEMORY gate bypassed");

    AST_TRAP: assert property (
        i_req_valid && !i_req_fetch && misaligned && !device_nxt &&
        !i_req_vector && !bus_fault_nxt && tgt_nxt != MRD_TGT_APB
        |=> o_align_fault == $past(i_unalign_trap))
        else $error("unaligned Normal handling wrong");

    AST_DEV_ALIGN: assert property (
        o_rsp_valid && o_is_device && $past(misaligned) &&
        !$past(i_req_fetch) && !o_bus_fault |-> o_align_fault)
        else $error("unaligned Device access passed");

    AST_NE_WAIT: assert property (
        o_wait_final_resp |-> o_is_device && !o_early_ack)
        else $error("nE wait without Device nE");

    AST_PRIVSYS_TYPE: assert property (
        i_req_valid && region == MRD_REG_PRIVSYS
        |=> o_is_device && !o_early_ack && o_wait_final_resp)
        else $error("private system not Device nGnRnE");

    AST_DEFAULT_TYPE: assert property (
        i_req_valid && !i_remap_valid && region != MRD_REG_CODE &&
        region != MRD_REG_SRAM && region != MRD_REG_EXTRAM
        |=> o_is_device)
        else $error("default Device region typed Normal");

    AST_IDLE: assert property (
        !o_rsp_valid |-> o_rsp_target == MRD_TGT_NONE && !o_bus_fault)
        else $error("target without request");

    COV_IMEM: cover property (o_rsp_target == MRD_TGT_IMEM);
    COV_APB: cover property (o_rsp_target == MRD_TGT_APB);
    COV_ALIGN: cover property (o_align_fault ##1 o_rsp_valid);
    COV_VENDOR_UNPRED: cover property (o_unpredictable);

endmodule // mrd_decoder

/* File: verif/mrd_sys_model.sv */
// Far-side model: tight memory windows and their security gate.
// Assumes the address is the one presented with the request.
module mrd_sys_model
    import mrd_pkg::*;
#(
    parameter logic [31:0] IMEM_SIZE = 32'h0001_0000,
    parameter logic [31:0] DMEM_SIZE = 32'h0001_0000
)(
    input  wire logic [31:0] i_addr,
    input  wire logic        i_deny,
    output logic             o_imem_hit,
    output logic             o_dmem_hit,
    output logic             o_gate_allow
);
    timeunit 1ns;
    timeprecision 1ns;

    // Hits only inside the configured windows, so misses must go to AXI
    assign o_imem_hit = (i_addr < IMEM_SIZE);
    assign o_dmem_hit = (i_addr >= MRD_SRAM_BASE) &&
                        (i_addr < MRD_SRAM_BASE + DMEM_SIZE);
    // Gate refuses only when a scenario asks for it
    assign o_gate_allow = ~i_deny;
endmodule // mrd_sys_model

/* File: verif/mrd_decoder_tb.sv */
// Self-checking bench for the memory region decoder.
// Assumes a one-cycle registered answer and the far-side model.
module mrd_decoder_tb
    import mrd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        i_ref_clk = 1'b0, i_reset_n = 1'b0, deny = 1'b0;
    logic        i_req_valid = 1'b0, i_req_fetch = 1'b0, i_req_write = 1'b0;
    logic        i_req_vector = 1'b0, i_cpu_secure = 1'b0;
    logic        i_internal_attr_ns = 1'b0, i_external_attr_ns = 1'b0;
    logic        i_periph_ahb_sel = 1'b0, i_privsys_internal = 1'b0;
    logic        i_unalign_trap = 1'b0, i_remap_valid = 1'b0;
    logic        i_remap_device = 1'b0, i_remap_no_early_ack = 1'b0;
    logic [31:0] i_req_addr = 32'h0;
    logic [1:0]  i_req_size = 2'h0;
    logic        i_imem_hit, i_dmem_hit, i_mem_gate_allow;
    logic        o_rsp_valid, o_rsp_write, o_bus_fault, o_align_fault;
    logic        o_is_device, o_early_ack, o_wait_final_resp, o_merge_ok;
    logic        o_coherent, o_unpredictable, o_ahb_nonsecure_flag;
    logic [31:0] o_rsp_addr, st, pr;
    logic [2:0]  o_rsp_target, o_axi_arprot, o_axi_awprot, o_apb_pprot;
    int          n_fail = 0, checked = 0;

    // Packed views keep each comparison to one call
    assign st = {19'h0, o_rsp_valid, o_rsp_target, o_bus_fault, o_align_fault,
                 o_is_device, o_early_ack, o_wait_final_resp, o_merge_ok,
                 o_coherent, o_unpredictable, o_rsp_write};
    assign pr = {22'h0, o_axi_arprot, o_axi_awprot, o_ahb_nonsecure_flag,
                 o_apb_pprot};

    // 50 MHz core clock
    always #10 i_ref_clk = ~i_ref_clk;

    mrd_decoder dut (.i_ref_clk, .i_reset_n, .i_req_valid, .i_req_addr,
        .i_req_fetch, .i_req_write, .i_req_size, .i_req_vector, .i_cpu_secure,
        .i_internal_attr_ns, .i_external_attr_ns, .i_imem_hit, .i_dmem_hit,
        .i_periph_ahb_sel, .i_privsys_internal, .i_mem_gate_allow,
        .i_unalign_trap, .i_remap_valid, .i_remap_device,
        .i_remap_no_early_ack, .o_rsp_valid, .o_rsp_addr, .o_rsp_target,
        .o_rsp_write, .o_bus_fault, .o_align_fault, .o_is_device,
        .o_early_ack, .o_wait_final_resp, .o_merge_ok, .o_coherent,
        .o_unpredictable, .o_axi_arprot, .o_axi_awprot,
        .o_ahb_nonsecure_flag, .o_apb_pprot);

    mrd_sys_model sys (.i_addr(i_req_addr), .i_deny(deny),
        .o_imem_hit(i_imem_hit), .o_dmem_hit(i_dmem_hit),
        .o_gate_allow(i_mem_gate_allow));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Clean decision; nE only matters on Device, merge on Normal or vector
    function automatic logic [31:0] ok(logic [2:0] t, logic d, logic ne,
                                       logic v, logic u);
        return {19'h0, 1'b1, t, 2'h0, d, ~(d & ne), d & ne, ~d | v, d, u,
                i_req_write};
    endfunction
    function automatic logic [31:0] flt(logic bf, logic af);
        return {19'h0, 1'b1, 3'h0, bf, af, 7'h0};
    endfunction
    function automatic logic [31:0] pe(logic f, logic ns);
        return {22'h0, f, ns, 1'b0, 1'b0, ns, 1'b0, ns, 1'b0, ns, 1'b0};
    endfunction

    task automatic end_sim();
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // One request, answer sampled after the edge that takes it
    task automatic go(logic [31:0] a, logic f, logic w, logic [1:0] z);
        i_req_valid = 1'b1;
        i_req_addr = a;
        i_req_fetch = f;
        i_req_write = w;
        i_req_size = z;
        @(posedge i_ref_clk);
        #1;
        chk(o_rsp_addr, a);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_code_sram();
        go(32'h0000_0100, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_IMEM, 0, 0, 0, 0));
        go(32'h1000_0000, 1'b1, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 0, 0, 0, 0));
        go(32'h2000_0010, 1'b0, 1'b1, 2'h2);
        chk(st, ok(MRD_TGT_DMEM, 0, 0, 0, 0));
        go(32'h3000_0000, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 0, 0, 0, 0));
        deny = 1'b1;
        go(32'h0000_0100, 1'b0, 1'b0, 2'h2);
        chk(st & 32'h1F80, flt(1, 0));
        deny = 1'b0;
    endtask

    task automatic t_periph_ext();
        i_periph_ahb_sel = 1'b1;
        go(32'h4000_0000, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AHB, 1, 0, 0, 0));
        go(32'h4000_0000, 1'b1, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 1, 0, 0, 0));
        i_periph_ahb_sel = 1'b0;
        go(32'h5FFF_FFFC, 1'b0, 1'b1, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 1, 0, 0, 0));
        go(32'h9FFF_FFFC, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 0, 0, 0, 0));
        go(32'hA000_0000, 1'b1, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 1, 0, 0, 0));
    endtask

    // System regions: fixed types, remap honoured only where allowed
    task automatic t_system();
        go(32'hE000_0000, 1'b1, 1'b0, 2'h2);
        chk(st & 32'h1F80, flt(1, 0));
        i_privsys_internal = 1'b1;
        go(32'hE000_E000, 1'b0, 1'b1, 2'h2);
        chk(st, ok(MRD_TGT_INTERNAL, 1, 1, 0, 0));
        i_privsys_internal = 1'b0;
        i_remap_valid = 1'b1;
        go(32'hE004_9000, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_APB, 1, 1, 0, 0));
        go(32'hE010_0000, 1'b0, 1'b0, 2'h2);
        chk(st & 32'h1F80, flt(1, 0));
        go(32'hF000_0000, 1'b1, 1'b0, 2'h2);
        chk(st & 32'h1F80, flt(1, 0));
        go(32'hF000_0004, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AHB, 1, 0, 0, 1));
        {i_remap_device, i_remap_no_early_ack} = 2'h3;
        go(32'hF000_0008, 1'b0, 1'b1, 2'h2);
        chk(st, ok(MRD_TGT_AHB, 1, 1, 0, 0));
        go(32'h6000_0000, 1'b0, 1'b1, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 1, 1, 0, 0));
        {i_remap_device, i_remap_no_early_ack} = 2'h0;
        go(32'hA000_0000, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 0, 0, 0, 0));
        i_remap_valid = 1'b0;
        i_req_vector = 1'b1;
        go(32'hA000_0004, 1'b0, 1'b0, 2'h2);
        chk(st, ok(MRD_TGT_AXI, 1, 0, 1, 0));
        i_req_vector = 1'b0;
    endtask

    task automatic t_align();
        go(32'h6000_0001, 1'b0, 1'b0, MRD_SIZE_WORD);
        chk(st, ok(MRD_TGT_AXI, 0, 0, 0, 0));
        i_unalign_trap = 1'b1;
        go(32'h6000_0001, 1'b0, 1'b0, MRD_SIZE_WORD);
        chk(st & 32'h1F80, flt(0, 1));
        i_unalign_trap = 1'b0;
        go(32'hA000_0002, 1'b0, 1'b1, MRD_SIZE_WORD);
        chk(st & 32'h1F80, flt(0, 1));
        go(32'hA000_0002, 1'b0, 1'b0, MRD_SIZE_HALF);
        chk(st, ok(MRD_TGT_AXI, 1, 0, 0, 0));
        i_req_vector = 1'b1;
        go(32'h6000_0004, 1'b0, 1'b0, MRD_SIZE_DWORD);
        chk(st & 32'h1F80, flt(0, 1));
        i_req_vector = 1'b0;
    endtask

    task automatic t_secure();
        i_cpu_secure = 1'b1;
        go(32'h6000_0000, 1'b0, 1'b0, 2'h2);
        chk(pr, pe(0, 0));
        i_internal_attr_ns = 1'b1;
        go(32'h6000_0000, 1'b0, 1'b1, 2'h2);
        chk(pr, pe(0, 0));
        i_external_attr_ns = 1'b1;
        go(32'hE004_9000, 1'b0, 1'b0, 2'h2);
        chk(pr, pe(0, 0));
        go(32'h1000_0000, 1'b1, 1'b0, 2'h2);
        chk(pr, pe(1, 1));
        i_cpu_secure = 1'b0;
        go(32'hE004_9000, 1'b0, 1'b0, 2'h2);
        chk(pr, pe(0, 1));
        i_req_valid = 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk(st, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and guard
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_ref_clk);
        #1;
        chk(st, 32'h0);
        chk(pr, 32'h0);
        i_reset_n = 1'b1;
        t_code_sram();
        t_periph_ext();
        t_system();
        t_align();
        t_secure();
        end_sim();
    end

    // Bounded run in case a scenario stalls
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        n_fail++;
        end_sim();
    end
endmodule // mrd_decoder_tb
